//--- tlsc_pkg.sv
// Shared constants and carriers for the tool life status control block
package tlsc_pkg;

    // Table shape
    localparam int NUM_GROUPS = 4;
    localparam int NUM_TOOLS  = 4;
    localparam int GW         = 2;
    localparam int TW         = 2;
    localparam int USAGE_W    = 16;
    localparam int ADDR_W     = 8;
    localparam int CTRL_W     = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_DESIG     = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_GROUP_SEL = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_TOOL_IDX  = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_TOOL_DATA = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT     = 8'h18;

    // Tool data status codes
    localparam logic [2:0] ST_UNUSED   = 3'h0;
    localparam logic [2:0] ST_IN_USE   = 3'h1;
    localparam logic [2:0] ST_LIFE_END = 3'h2;
    localparam logic [2:0] ST_ALARM1   = 3'h3;
    localparam logic [2:0] ST_ALARM2   = 3'h4;

    // Reset values
    localparam logic [CTRL_W-1:0]  CTRL_RESET  = 8'h00;
    localparam logic [USAGE_W-1:0] LIMIT_RESET = 16'hFFFF;
    localparam logic [USAGE_W-1:0] USAGE_MAX   = 16'hFFFF;
    localparam logic [USAGE_W-1:0] USAGE_ZERO  = 16'h0000;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    // Control word written by the sequence program, bit 7 first
    typedef struct packed {
        logic fitted;
        logic lathe_type;
        logic recalculation_request;
        logic tool_change_reset;
        logic tool_second_alarm_in;
        logic tool_alarm_skip_in;
        logic usage_count_enable;
        logic life_management_enable;
    } tlsc_ctrl_t;

    // Clear target designation
    typedef struct packed {
        logic          all_exceeded;
        logic [GW-1:0] group;
    } tlsc_desig_t;

    // One tool's data
    typedef struct packed {
        logic [2:0]         status;
        logic [USAGE_W-1:0] usage;
    } tlsc_tool_t;

endpackage : tlsc_pkg

//--- tlsc_sync2.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module tlsc_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule : tlsc_sync2

//--- tlsc_top.sv
// Tool life status control with AHB-Lite register slave
`timescale 1ns/1ps
module tlsc_top
    import tlsc_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          hsel_i,
    input  wire logic [31:0]   haddr_i,
    input  wire logic [1:0]    htrans_i,
    input  wire logic          hwrite_i,
    input  wire logic [2:0]    hsize_i,
    input  wire logic [31:0]   hwdata_i,
    input  wire logic          hready_i,
    output logic      [31:0]   hrdata_o,
    output logic               hreadyout_o,
    output logic               hresp_o,
    input  wire logic          usage_tick_i,
    input  wire logic          motion_cmd_i,
    output logic               managing_o,
    output logic               count_active_o,
    output logic      [GW-1:0] cur_group_o,
    output logic      [TW-1:0] cur_tool_o
);

    // Bus state
    logic              wr_pend;
    logic              rd_pend;
    logic [ADDR_W-1:0] addr_q;
    logic              next_wr_pend;
    logic              next_rd_pend;
    logic [ADDR_W-1:0] next_addr_q;
    logic [31:0]       next_hrdata;
    logic [31:0]       rd_mux;

    // Block state
    tlsc_ctrl_t         ctrl;
    tlsc_ctrl_t         ctrl_prev;
    tlsc_desig_t        desig;
    tlsc_tool_t         tbl [NUM_GROUPS][NUM_TOOLS];
    logic [GW-1:0]      cur_group;
    logic [TW-1:0]      cur_tool;
    logic               active;
    logic               reset_pending;
    logic               sel_blocked;
    logic               sel_refused;
    logic [GW+TW-1:0]   tool_idx;
    logic [USAGE_W-1:0] life_limit;
    logic [1:0]         pins_q;

    tlsc_ctrl_t         next_ctrl;
    tlsc_desig_t        next_desig;
    tlsc_tool_t         next_tbl [NUM_GROUPS][NUM_TOOLS];
    logic [GW-1:0]      next_cur_group;
    logic [TW-1:0]      next_cur_tool;
    logic               next_active;
    logic               next_reset_pending;
    logic               next_sel_blocked;
    logic               next_sel_refused;
    logic [GW+TW-1:0]   next_tool_idx;
    logic [USAGE_W-1:0] next_life_limit;

    // Synchronised pins: {motion, usage tick}
    logic [1:0] pins_s;
    logic       tick_rise;
    logic       motion_rise;

    tlsc_sync2 #(
        .WIDTH (2)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({motion_cmd_i, usage_tick_i}),
        .sync_o  (pins_s)
    );

    assign tick_rise   = pins_s[0] & ~pins_q[0];
    assign motion_rise = pins_s[1] & ~pins_q[1];

    // Qualified enables
    logic       mgmt_on;
    logic       count_on;
    tlsc_ctrl_t rise;
    logic [NUM_GROUPS-1:0] exceeded;

    assign rise     = ctrl & ~ctrl_prev;
    assign mgmt_on  = ctrl.fitted
                      & (ctrl.life_management_enable | ctrl.lathe_type);
    assign count_on = mgmt_on & ctrl.usage_count_enable & active;

    // A group counts as exceeded once any tool reached the limit
    always_comb begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            exceeded[g] = 1'b0;
            for (int t = 0; t < NUM_TOOLS; t++) begin
                if (tbl[g][t].status == ST_LIFE_END
                    || tbl[g][t].usage >= life_limit) begin
                    exceeded[g] = 1'b1;
                end
            end
        end
    end

    // AHB-Lite slave: writes zero-wait, reads take one wait state
    always_comb begin
        next_wr_pend = 1'b0;
        next_rd_pend = 1'b0;
        next_addr_q  = addr_q;
        next_hrdata  = hrdata_o;
        if (rd_pend) begin
            next_hrdata = rd_mux;
        end
        if (hsel_i && hready_i && htrans_i == HTRANS_NONSEQ) begin
            next_wr_pend = hwrite_i;
            next_rd_pend = ~hwrite_i;
            next_addr_q  = haddr_i[ADDR_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend  <= 1'b0;
            rd_pend  <= 1'b0;
            addr_q   <= '0;
            hrdata_o <= '0;
        end else begin
            wr_pend  <= next_wr_pend;
            rd_pend  <= next_rd_pend;
            addr_q   <= next_addr_q;
            hrdata_o <= next_hrdata;
        end
    end

    assign hreadyout_o = ~rd_pend;
    assign hresp_o     = HRESP_OKAY;

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        unique case (addr_q)
            ADDR_CTRL:      rd_mux[CTRL_W-1:0] = ctrl;
            ADDR_DESIG:     rd_mux[GW:0] = desig;
            ADDR_GROUP_SEL: rd_mux[GW-1:0] = cur_group;
            ADDR_STATUS:    rd_mux[GW+TW+5:0] = {count_on, mgmt_on,
                                sel_refused, sel_blocked, reset_pending,
                                active, cur_group, cur_tool};
            ADDR_TOOL_IDX:  rd_mux[GW+TW-1:0] = tool_idx;
            ADDR_TOOL_DATA: rd_mux[USAGE_W+2:0] =
                tbl[tool_idx[GW+TW-1:TW]][tool_idx[TW-1:0]];
            ADDR_LIMIT:     rd_mux[USAGE_W-1:0] = life_limit;
            default:        rd_mux = '0;
        endcase
    end

    // Tool table, selection and counting
    always_comb begin
        logic          sel_req;
        logic [GW-1:0] sel_grp;
        logic [TW-1:0] pick;
        logic          hit;
        logic          rst_hit;
        sel_req            = 1'b0;
        sel_grp            = '0;
        pick               = '0;
        hit                = 1'b0;
        rst_hit            = rise.tool_change_reset && ctrl.fitted
                             && ctrl.lathe_type;
        next_ctrl          = ctrl;
        next_desig         = desig;
        next_tbl           = tbl;
        next_cur_group     = cur_group;
        next_cur_tool      = cur_tool;
        next_active        = active;
        next_reset_pending = reset_pending;
        next_sel_blocked   = sel_blocked;
        next_sel_refused   = sel_refused;
        next_tool_idx      = tool_idx;
        next_life_limit    = life_limit;

        // Register writes land in the data phase
        if (wr_pend) begin
            unique case (addr_q)
                ADDR_CTRL:      next_ctrl = tlsc_ctrl_t'(hwdata_i[CTRL_W-1:0]);
                ADDR_DESIG:     next_desig = tlsc_desig_t'(hwdata_i[GW:0]);
                ADDR_GROUP_SEL: begin
                    sel_req = 1'b1;
                    sel_grp = hwdata_i[GW-1:0];
                end
                ADDR_TOOL_IDX:  next_tool_idx = hwdata_i[GW+TW-1:0];
                ADDR_LIMIT:     next_life_limit = hwdata_i[USAGE_W-1:0];
                default:        ;
            endcase
        end

        // Usage accrues to the tool in use, saturating at USAGE_MAX
        if (count_on && tick_rise) begin
            if (tbl[cur_group][cur_tool].usage != USAGE_MAX) begin
                next_tbl[cur_group][cur_tool].usage =
                    tbl[cur_group][cur_tool].usage + 1'b1;
            end
            if (tbl[cur_group][cur_tool].usage + 1'b1 >= life_limit
                && tbl[cur_group][cur_tool].status == ST_IN_USE) begin
                next_tbl[cur_group][cur_tool].status = ST_LIFE_END;
            end
        end

        // Alarm inputs act on their rising edge
        if (rise.tool_alarm_skip_in && mgmt_on) begin
            next_tbl[cur_group][cur_tool].status = ST_ALARM1;
        end
        if (rise.tool_second_alarm_in && ctrl.fitted
            && ctrl.life_management_enable) begin
            next_tbl[cur_group][cur_tool].status = ST_ALARM2;
        end

        // Tool change reset clears the designated groups
        if (rst_hit) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (desig.all_exceeded ? exceeded[g]
                                       : desig.group == GW'(g)) begin
                    for (int t = 0; t < NUM_TOOLS; t++) begin
                        next_tbl[g][t].usage  = USAGE_ZERO;
                        next_tbl[g][t].status = ST_UNUSED;
                    end
                end
            end
            next_active        = 1'b0;
            next_reset_pending = 1'b1;
            next_sel_blocked   = 1'b1;
        end

        // Motion or a recalculation request drops the stale look-ahead;
        // a tool change reset in the same cycle wins and keeps the block
        if ((motion_rise || rise.recalculation_request)
            && !rst_hit) begin
            next_sel_blocked = 1'b0;
        end

        // Group selection; first usable tool, head tool after a reset.
        // A select meeting a reset is refused so the reset flags stand
        if (sel_req) begin
            if (sel_blocked || rst_hit) begin
                next_sel_refused = 1'b1;
            end else begin
                for (int t = NUM_TOOLS - 1; t >= 0; t--) begin
                    if (tbl[sel_grp][t].status == ST_UNUSED
                        || tbl[sel_grp][t].status == ST_IN_USE) begin
                        pick = TW'(t);
                        hit  = 1'b1;
                    end
                end
                if (reset_pending || !hit) begin
                    pick = '0;
                end
                next_sel_refused   = 1'b0;
                next_reset_pending = 1'b0;
                next_cur_group     = sel_grp;
                next_cur_tool      = pick;
                next_active        = ctrl.fitted;
                if (next_tbl[sel_grp][pick].status == ST_UNUSED) begin
                    next_tbl[sel_grp][pick].status = ST_IN_USE;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl          <= tlsc_ctrl_t'(CTRL_RESET);
            ctrl_prev     <= tlsc_ctrl_t'(CTRL_RESET);
            desig         <= '0;
            cur_group     <= '0;
            cur_tool      <= '0;
            active        <= 1'b0;
            reset_pending <= 1'b0;
            sel_blocked   <= 1'b0;
            sel_refused   <= 1'b0;
            tool_idx      <= '0;
            life_limit    <= LIMIT_RESET;
            pins_q        <= '0;
            for (int g = 0; g < NUM_GROUPS; g++) begin
                for (int t = 0; t < NUM_TOOLS; t++) begin
                    tbl[g][t] <= '0;
                end
            end
        end else begin
            ctrl          <= next_ctrl;
            ctrl_prev     <= ctrl;
            desig         <= next_desig;
            cur_group     <= next_cur_group;
            cur_tool      <= next_cur_tool;
            active        <= next_active;
            reset_pending <= next_reset_pending;
            sel_blocked   <= next_sel_blocked;
            sel_refused   <= next_sel_refused;
            tool_idx      <= next_tool_idx;
            life_limit    <= next_life_limit;
            pins_q        <= pins_s;
            tbl           <= next_tbl;
        end
    end

    // Status outputs follow the registered state
    assign managing_o     = mgmt_on;
    assign count_active_o = count_on;
    assign cur_group_o    = cur_group;
    assign cur_tool_o     = cur_tool;

endmodule : tlsc_top

//--- tlsc_assertions.sv
// Port assertions for the tool life status control block
`timescale 1ns/1ps
module tlsc_checker
    import tlsc_pkg::*;
(
    input wire logic          clk_i,
    input wire logic          rst_n_i,
    input wire logic          hsel_i,
    input wire logic [31:0]   haddr_i,
    input wire logic [1:0]    htrans_i,
    input wire logic          hwrite_i,
    input wire logic [31:0]   hwdata_i,
    input wire logic          hready_i,
    input wire logic [31:0]   hrdata_o,
    input wire logic          hreadyout_o,
    input wire logic          hresp_o,
    input wire logic          managing_o,
    input wire logic          count_active_o,
    input wire logic [GW-1:0] cur_group_o
);
    logic       take, wr_ph, rd_ph, next_wr_ph, next_rd_ph, ctrl_wr, sel_wr;
    logic [7:0] ph_adr, next_ph_adr;
    tlsc_ctrl_t sh, next_sh, wd;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Taken transfers and writes completing in their data phase
    assign take    = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
    assign wd      = hwdata_i[7:0];
    assign ctrl_wr = wr_ph & hready_i & (ph_adr == ADDR_CTRL);
    assign sel_wr  = wr_ph & hready_i & (ph_adr == ADDR_GROUP_SEL);
    // Phase tracker and control shadow; a stall keeps the old phase
    always_comb begin
        next_wr_ph  = hready_i ? take & hwrite_i : wr_ph;
        next_rd_ph  = hready_i ? take & !hwrite_i : rd_ph;
        next_ph_adr = hready_i ? haddr_i[7:0] : ph_adr;
        next_sh     = ctrl_wr ? wd : sh;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ph  <= 1'b0;
            rd_ph  <= 1'b0;
            ph_adr <= 8'h00;
            sh     <= CTRL_RESET;
        end else begin
            wr_ph  <= next_wr_ph;
            rd_ph  <= next_rd_ph;
            ph_adr <= next_ph_adr;
            sh     <= next_sh;
        end
    end
    sequence s_one_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    a_resp_okay: assert property (hresp_o == HRESP_OKAY)
        else $error("response not OKAY");
    a_write_no_wait: assert property (take && hwrite_i |=> hreadyout_o)
        else $error("write stalled");
    a_read_one_wait: assert property (take && !hwrite_i |=> s_one_wait)
        else $error("read not one wait state");
    a_rdata_stands: assert property (!$past(rd_ph) |-> $stable(hrdata_o))
        else $error("read data moved outside a read");
    a_manage_follows: assert property (
        managing_o == (sh.fitted & (sh.life_management_enable
                                    | sh.lathe_type)))
        else $error("managing flag wrong");
    a_count_enabled: assert property (
        count_active_o |-> managing_o && sh.usage_count_enable)
        else $error("counting while disabled");
    a_count_machining: assert property (
        count_active_o && !sh.lathe_type |-> sh.life_management_enable)
        else $error("machining counts unmanaged");
    a_reset_stops: assert property (
        ctrl_wr && wd.tool_change_reset && !sh.tool_change_reset
        && wd.lathe_type && wd.fitted |-> ##2 !count_active_o)
        else $error("counting survived tool change reset");
    a_group_by_select: assert property (
        $changed(cur_group_o) |-> $past(sel_wr) || $past(sel_wr, 2))
        else $error("group changed without selection");
endmodule : tlsc_checker
bind tlsc_top tlsc_checker u_checker (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .managing_o(managing_o),
    .count_active_o(count_active_o), .cur_group_o(cur_group_o));

//--- tlsc_machine.sv
// Machine-side model pulsing the usage and motion pins
`timescale 1ns/1ps
module tlsc_machine (
    input  wire logic clk_i,
    output logic      usage_tick_o,
    output logic      motion_cmd_o
);
    // Both pins rest low between pulses
    initial begin
        usage_tick_o = 1'b0;
        motion_cmd_o = 1'b0;
    end
    // Three clocks high and low, a clock of margin over the synchroniser
    task automatic pulse(input logic motion, input int n);
        repeat (n) begin
            @(posedge clk_i);
            if (motion) begin
                motion_cmd_o <= 1'b1;
            end else begin
                usage_tick_o <= 1'b1;
            end
            repeat (3) @(posedge clk_i);
            usage_tick_o <= 1'b0;
            motion_cmd_o <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask : pulse
endmodule : tlsc_machine

//--- tb_tool_life_status_control.sv
// Self-checking bench for the tool life status control block
`timescale 1ns/1ps
module tb_tool_life_status_control
    import tlsc_pkg::*;
;
    logic          clk_i = 1'b0, rst_n_i = 1'b0, hwrite = 1'b0;
    logic [1:0]    htrans = 2'h0;
    logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic          hready, hresp, tick, motion, managing, counting;
    logic [GW-1:0] group;
    logic [TW-1:0] tool;
    logic [7:0]    pre[4]  = '{8'h80, 8'h80, 8'h81, 8'h81};
    logic [7:0]    post[4] = '{8'h88, 8'h84, 8'h85, 8'h89};
    logic [2:0]    code[4] = '{ST_IN_USE, ST_IN_USE, ST_ALARM1, ST_ALARM2};
    int            fails = 0, checks = 0;
    always #2.5 clk_i = ~clk_i;
    tlsc_machine mach (.clk_i(clk_i), .usage_tick_o(tick),
                       .motion_cmd_o(motion));
    tlsc_top dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .usage_tick_i(tick),
        .motion_cmd_i(motion), .managing_o(managing),
        .count_active_o(counting), .cur_group_o(group), .cur_tool_o(tool));
    // Verdict; also where every timeout lands
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    // Bounded wait for hready sampled high at a rising edge
    task automatic wait_ready();
        for (int n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (hready === 1'b1) return;
        end
        fails++;
        wrap_up();
    endtask : wait_ready
    // One single transfer; the 1 ns tail lets outputs settle for checks
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        #1;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(nm, e, rd);
    endtask : rdc
    // Tool slot index is group then tool
    task automatic tchk(input string nm, input logic [3:0] i,
                        input logic [31:0] e);
        wr(ADDR_TOOL_IDX, {28'h000_0000, i});
        rdc(nm, ADDR_TOOL_DATA, e);
    endtask : tchk
    // Scenarios in order: reset, enable, alarms, counting, lathe clears
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdc("ctrl", ADDR_CTRL, 32'h0);
        rdc("limit", ADDR_LIMIT, 32'h0000_FFFF);
        rdc("unmapped", 8'h1C, 32'h0);
        wr(ADDR_CTRL, 32'h0000_0080);
        check("managing off", 32'h0, managing);
        wr(ADDR_CTRL, 32'h0000_0081);
        check("managing on", 32'h1, managing);
        wr(ADDR_GROUP_SEL, 32'h1);
        rdc("status", ADDR_STATUS, 32'h0000_0114);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL, {24'h00_0000, pre[i]});
            wr(ADDR_CTRL, {24'h00_0000, post[i]});
            tchk("alarm", 4'h4, {13'h0, code[i], 16'h0});
        end
        wr(ADDR_GROUP_SEL, 32'h2);
        wr(ADDR_CTRL, 32'h0000_0082);
        mach.pulse(1'b0, 2);
        tchk("ignored", 4'h8, 32'h0001_0000);
        wr(ADDR_CTRL, 32'h0000_0083);
        mach.pulse(1'b0, 3);
        tchk("counted", 4'h8, 32'h0001_0003);
        check("counting", 32'h1, counting);
        wr(ADDR_CTRL, 32'h0000_0081);
        mach.pulse(1'b0, 2);
        tchk("held", 4'h8, 32'h0001_0003);
        wr(ADDR_CTRL, 32'h0000_00C3);
        wr(ADDR_DESIG, 32'h2);
        mach.pulse(1'b0, 2);
        tchk("accrued", 4'h8, 32'h0001_0005);
        wr(ADDR_CTRL, 32'h0000_00D3);
        mach.pulse(1'b0, 1);
        tchk("cleared", 4'h8, 32'h0);
        check("stopped", 32'h0, counting);
        tchk("kept", 4'h4, 32'h0004_0000);
        wr(ADDR_GROUP_SEL, 32'h3);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check("blocked", 32'h7, rd[7:5]);
        check("group held", 32'h2, group);
        wr(ADDR_CTRL, 32'h0000_00E3);
        wr(ADDR_GROUP_SEL, 32'h1);
        rdc("group", ADDR_GROUP_SEL, 32'h1);
        check("head tool", 32'h0, tool);
        wr(ADDR_LIMIT, 32'h1);
        mach.pulse(1'b0, 1);
        wr(ADDR_DESIG, 32'h4);
        wr(ADDR_CTRL, 32'h0000_00D3);
        tchk("exceeded", 4'h4, 32'h0);
        mach.pulse(1'b1, 1);
        wr(ADDR_GROUP_SEL, 32'h3);
        rdc("after motion", ADDR_GROUP_SEL, 32'h3);
        // Lathe type: alarm/skip works without enable, second alarm not
        wr(ADDR_CTRL, 32'h0000_00C0);
        check("lathe managing", 32'h1, managing);
        wr(ADDR_CTRL, 32'h0000_00C4);
        wr(ADDR_CTRL, 32'h0000_00C8);
        tchk("lathe alarm", 4'hC, 32'h0003_0000);
        wrap_up();
    end
endmodule : tb_tool_life_status_control
